// *** verilog/kbcp_pkg.sv ***
`default_nettype none
package kbcp_pkg;
  localparam logic [7:0] KBCP_ADDR_DATA = 8'h60;
  localparam logic [7:0] KBCP_ADDR_CMD = 8'h64;
  localparam int KBCP_ADDR_TWO_BIT = 2;
  localparam int KBCP_ST_OBF = 0;
  localparam int KBCP_ST_IBF = 1;
  localparam int KBCP_ST_CD = 3;
  localparam logic [7:0] KBCP_STATUS_RESET = 8'h00;
  localparam logic [7:0] KBCP_UD_MASK = 8'hf4;
  // port 2 bit positions
  localparam int KBCP_P2_A20 = 1;
  localparam int KBCP_P2_MOUSE_DATA_PIN = 2;
  localparam int KBCP_P2_MCLK = 3;
  localparam int KBCP_P2_KBD_IRQ_OUT = 4;
  localparam int KBCP_P2_AIRQ = 5;
  localparam int KBCP_P2_KEYBOARD_CLOCK_PIN = 6;
  localparam int KBCP_P2_KEYBOARD_DATA_PIN = 7;
  localparam logic [7:0] KBCP_P2_RESET = 8'h00;
  // push-pull high-drive pulse
  localparam int KBCP_CLK_NS = 50;
  localparam int KBCP_PULLUP_DRIVE_NS = 500;
  localparam int KBCP_PULLUP_CYCLES_I = KBCP_PULLUP_DRIVE_NS / KBCP_CLK_NS;
  localparam logic [3:0] KBCP_PULLUP_CYCLES = KBCP_PULLUP_CYCLES_I[3:0];
  typedef enum {KBCP_RUN, KBCP_HALT, KBCP_STOP} kbcp_pwr_e;
endpackage : kbcp_pkg
`default_nettype wire

// *** verilog/kbcp_sync.sv ***
`default_nettype none
module kbcp_sync (
  input wire logic i_ref_clk, // clock
  input wire logic i_reset, // sync reset
  input wire logic i_async, // pin level
  output logic o_sync // synchronised level
);
  logic stage1;
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      stage1 <= 1'b1;
      o_sync <= 1'b1;
    end else begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end
endmodule : kbcp_sync
`default_nettype wire

// *** verilog/kbcp_pin_drv.sv ***
`default_nettype none
module kbcp_pin_drv
  import kbcp_pkg::*;
(
  input wire logic i_ref_clk, // clock
  input wire logic i_reset, // sync reset
  input wire logic i_level, // wanted pin level
  input wire logic i_open_drain, // 1 open drain, 0 push-pull
  output logic o_pin_out, // pin output value
  output logic o_pin_oe // pin output enable
);
  logic [3:0] high_cnt;
  logic prev_level;
  wire rise = i_level && !prev_level;
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      prev_level <= 1'b0;
      high_cnt <= 4'h0;
    end else begin
      prev_level <= i_level;
      if (!i_level || i_open_drain) begin
        high_cnt <= 4'h0;
      end else if (rise) begin
        high_cnt <= KBCP_PULLUP_CYCLES;
      end else if (high_cnt != 4'h0) begin
        high_cnt <= high_cnt - 4'h1;
      end
    end
  end
  // low drives; high drives briefly only in push-pull
  assign o_pin_out = i_level;
  assign o_pin_oe = !i_level || (!i_open_drain && (rise || high_cnt != 4'h0));

  a_pp_release: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    !i_open_drain && i_level && high_cnt == 4'h1 |=> !o_pin_oe || !i_level)
    else $error("push-pull high drive not released");
  a_od_no_drive: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    i_open_drain && i_level |-> !o_pin_oe) else $error("open drain enabled high");
endmodule : kbcp_pin_drv
`default_nettype wire

// *** verilog/kbcp_host_port.sv ***
// What this block does
// - data write stores byte, clears C/D, sets IN_BUF_FULL
// - command write stores byte, sets C/D, IN_BUF_FULL
// - gated: data read clears OUT_BUF_FULL and kbd irq
// - status read changes no buffer
// - core output write sets OUT_BUF_FULL
// - C/D bit follows host address line two
// - gated kbd irq is OUT_BUF_FULL and port bit
// - ungated kbd irq follows port bit
// - kbd irq zero after reset
// - gated aux irq is inverted IN_BUF_FULL and port bit
// - ungated aux irq follows port bit
// - port bit drives gate A20 output
// - push-pull high drive released after eleven clocks
// - open drain never drives high
// - controller pins cannot become inputs/inverted
// - kbd pins inverted, read back on inputs
// - mouse pins inverted, read back on inputs
// - halt stops core until reset/host write
// - halt exit: call interrupt if enabled
// - stop disables oscillator until reset/host write
// - core input read clears IN_BUF_FULL
// - status cleared on reset
`default_nettype none
module kbcp_host_port
  import kbcp_pkg::*;
(
  input wire logic i_ref_clk, // 20 MHz controller clock
  input wire logic i_reset, // sync reset, active high
  input wire logic [7:0] i_host_addr, // host I/O address
  input wire logic i_host_wr, // host write strobe, one cycle
  input wire logic i_host_rd, // host read strobe, one cycle
  input wire logic [7:0] i_host_wdata, // host write data
  output logic [7:0] o_host_rdata, // host read data, registered
  output logic o_host_rvalid, // read data valid pulse
  input wire logic i_core_out_wr, // core writes output buffer
  input wire logic [7:0] i_core_out_data, // core output byte
  input wire logic i_core_in_rd, // core reads input buffer
  output logic [7:0] o_core_input_buffer, // input buffer byte
  input wire logic i_core_status_wr, // core writes status ud bits
  input wire logic [7:0] i_core_status_data, // new ud bits
  input wire logic i_en_flags, // enable-flags executed
  input wire logic i_port2_wr, // core writes port 2
  input wire logic [7:0] i_port2_data, // port 2 value
  input wire logic i_open_drain, // pin mode, 1 open drain
  input wire logic i_gp_input_cfg, // gp config: make pins inputs
  input wire logic i_gp_invert_cfg, // gp config: invert pins
  input wire logic i_halt, // core executes halt
  input wire logic i_stop, // core executes stop
  input wire logic i_ibf_int_en, // core input interrupt enabled
  output logic o_alu_clk_en, // arithmetic unit clock enable
  output logic o_osc_en, // oscillator enable
  output logic o_wake_call_int, // wake pulse: call interrupt routine
  output logic o_wake_next, // wake pulse: next instruction
  output logic [7:0] o_status, // status byte to core
  output logic [7:0] o_port2, // port 2 latch
  output logic o_kbd_irq_out, // keyboard interrupt
  output logic o_aux_irq_out, // auxiliary interrupt
  output logic o_core_ibf_irq, // core input interrupt
  output logic o_gate_a20, // gate A20 output
  input wire logic i_keyboard_clock_pin, // pin level in
  output logic o_keyboard_clock_pin_out, // pin value
  output logic o_keyboard_clock_pin_oe, // pin enable
  input wire logic i_keyboard_data_pin, // pin level in
  output logic o_keyboard_data_pin_out, // pin value
  output logic o_keyboard_data_pin_oe, // pin enable
  input wire logic i_mouse_clock_pin, // pin level in
  output logic o_mouse_clock_pin_out, // pin value
  output logic o_mouse_clock_pin_oe, // pin enable
  input wire logic i_mouse_data_pin, // pin level in
  output logic o_mouse_data_pin_out, // pin value
  output logic o_mouse_data_pin_oe, // pin enable
  output logic o_test_in_kbd_clk, // test input 0
  output logic o_test_in_mouse_clk, // test input 1
  output logic o_port_in_kbd_dat, // port 1 bit 0
  output logic o_port_in_mouse_dat // port 1 bit 1
);
  import kbcp_pkg::*;

  logic [7:0] in_buf;
  logic [7:0] out_buf;
  logic [7:0] status;
  logic [7:0] port2;
  kbcp_pwr_e pwr_state;
  kbcp_pwr_e next_pwr_state;

  wire sel_data = (i_host_addr == KBCP_ADDR_DATA);
  wire sel_cmd = (i_host_addr == KBCP_ADDR_CMD);
  wire host_buf_wr = i_host_wr && (sel_data || sel_cmd);
  wire host_data_rd = i_host_rd && sel_data;
  wire host_status_rd = i_host_rd && sel_cmd;
  wire host_addr_line_two = i_host_addr[KBCP_ADDR_TWO_BIT];
  wire out_buf_full = status[KBCP_ST_OBF];
  wire in_buf_full = status[KBCP_ST_IBF];
  wire clear_obf = host_data_rd && i_en_flags;

  // status: set beats clear for both flags
  logic [7:0] next_status;
  always_comb begin
    next_status = status;
    if (i_core_status_wr) begin
      next_status = (status & ~KBCP_UD_MASK) | (i_core_status_data & KBCP_UD_MASK);
    end
    if (i_core_in_rd) begin
      next_status[KBCP_ST_IBF] = 1'b0;
    end
    if (clear_obf) begin
      next_status[KBCP_ST_OBF] = 1'b0;
    end
    if (i_core_out_wr) begin
      next_status[KBCP_ST_OBF] = 1'b1;
    end
    if (host_buf_wr) begin
      next_status[KBCP_ST_IBF] = 1'b1;
      next_status[KBCP_ST_CD] = host_addr_line_two;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      status <= KBCP_STATUS_RESET;
      port2 <= KBCP_P2_RESET;
      in_buf <= 8'h00;
      out_buf <= 8'h00;
    end else begin
      status <= next_status;
      if (host_buf_wr) begin
        in_buf <= i_host_wdata;
      end
      if (i_core_out_wr) begin
        out_buf <= i_core_out_data;
      end
      if (i_port2_wr) begin
        port2 <= i_port2_data;
      end
    end
  end

  // host read data; status read touches no buffer
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_host_rdata <= 8'h00;
      o_host_rvalid <= 1'b0;
    end else begin
      o_host_rvalid <= host_data_rd || host_status_rd;
      if (host_data_rd) begin
        o_host_rdata <= out_buf;
      end else if (host_status_rd) begin
        o_host_rdata <= status;
      end
    end
  end

  // interrupts
  wire kbd_irq_gated = port2[KBCP_P2_KBD_IRQ_OUT] && out_buf_full;
  wire aux_irq_gated = port2[KBCP_P2_AIRQ] && !in_buf_full;
  assign o_kbd_irq_out = i_en_flags ? kbd_irq_gated : port2[KBCP_P2_KBD_IRQ_OUT];
  assign o_aux_irq_out = i_en_flags ? aux_irq_gated : port2[KBCP_P2_AIRQ];
  assign o_core_ibf_irq = in_buf_full && i_ibf_int_en;
  assign o_gate_a20 = port2[KBCP_P2_A20];
  assign o_status = status;
  assign o_port2 = port2;
  assign o_core_input_buffer = in_buf;

  // power modes
  wire wake = host_buf_wr;
  always_comb begin
    next_pwr_state = pwr_state;
    case (pwr_state)
      KBCP_RUN: begin
        if (i_stop) begin
          next_pwr_state = KBCP_STOP;
        end else if (i_halt) begin
          next_pwr_state = KBCP_HALT;
        end
      end
      KBCP_HALT, KBCP_STOP: begin
        if (wake) begin
          next_pwr_state = KBCP_RUN;
        end
      end
      default: next_pwr_state = KBCP_RUN;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      pwr_state <= KBCP_RUN;
      o_wake_call_int <= 1'b0;
      o_wake_next <= 1'b0;
    end else begin
      pwr_state <= next_pwr_state;
      o_wake_call_int <= (pwr_state != KBCP_RUN) && wake && i_ibf_int_en;
      o_wake_next <= (pwr_state != KBCP_RUN) && wake && !i_ibf_int_en;
    end
  end
  assign o_alu_clk_en = (pwr_state == KBCP_RUN);
  assign o_osc_en = (pwr_state != KBCP_STOP);

  // pins: port bits inverted, gp config ignored
  logic unused_gp;
  assign unused_gp = i_gp_input_cfg ^ i_gp_invert_cfg;
  wire [3:0] pin_level = ~{port2[KBCP_P2_KEYBOARD_CLOCK_PIN], port2[KBCP_P2_KEYBOARD_DATA_PIN],
                           port2[KBCP_P2_MCLK], port2[KBCP_P2_MOUSE_DATA_PIN]};
  wire [3:0] pin_in = {i_keyboard_clock_pin, i_keyboard_data_pin,
                       i_mouse_clock_pin, i_mouse_data_pin};
  logic [3:0] pin_out;
  logic [3:0] pin_oe;
  logic [3:0] pin_sync;
  genvar g;
  for (g = 0; g < 4; g++) begin : g_pin
    kbcp_pin_drv u_drv (
      .i_ref_clk(i_ref_clk),
      .i_reset(i_reset),
      .i_level(pin_level[g]),
      .i_open_drain(i_open_drain),
      .o_pin_out(pin_out[g]),
      .o_pin_oe(pin_oe[g])
    );
    kbcp_sync u_sync (
      .i_ref_clk(i_ref_clk),
      .i_reset(i_reset),
      .i_async(pin_in[g]),
      .o_sync(pin_sync[g])
    );
  end
  assign {o_keyboard_clock_pin_out, o_keyboard_data_pin_out,
          o_mouse_clock_pin_out, o_mouse_data_pin_out} = pin_out;
  assign {o_keyboard_clock_pin_oe, o_keyboard_data_pin_oe,
          o_mouse_clock_pin_oe, o_mouse_data_pin_oe} = pin_oe;
  assign o_test_in_kbd_clk = pin_sync[3];
  assign o_port_in_kbd_dat = pin_sync[2];
  assign o_test_in_mouse_clk = pin_sync[1];
  assign o_port_in_mouse_dat = pin_sync[0];

  // checks
  a_data_write: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    i_host_wr && sel_data |=> status[KBCP_ST_IBF] && !status[KBCP_ST_CD]
    && in_buf == $past(i_host_wdata)) else $error("data write flags wrong");
  a_cmd_write: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    i_host_wr && sel_cmd |=> status[KBCP_ST_IBF] && status[KBCP_ST_CD])
    else $error("command write flags wrong");
  a_data_read: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    host_data_rd && i_en_flags && !i_core_out_wr |=> !out_buf_full
    && o_host_rdata == $past(out_buf)) else $error("data read wrong");
  a_status_read: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    host_status_rd && !i_host_wr && !i_core_out_wr |=> $stable(in_buf) && $stable(out_buf)
    && o_host_rdata == $past(status)) else $error("status read wrong");
  a_obf_set: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    i_core_out_wr |=> out_buf_full) else $error("obf not set");
  a_kbd_irq: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    i_en_flags |-> o_kbd_irq_out == (port2[KBCP_P2_KBD_IRQ_OUT] && out_buf_full))
    else $error("kbd irq wrong");
  a_aux_irq: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    i_en_flags && port2[KBCP_P2_AIRQ] |-> o_aux_irq_out == !in_buf_full)
    else $error("aux irq wrong");
  a_irq_reset: assert property (@(posedge i_ref_clk)
    $fell(i_reset) |-> !o_kbd_irq_out) else $error("kbd irq after reset");
  sequence s_halted;
    pwr_state == KBCP_HALT && !wake;
  endsequence
  a_halt_hold: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    s_halted |=> !o_alu_clk_en) else $error("alu ran in halt");
  a_stop_osc: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    pwr_state == KBCP_RUN && i_stop |=> !o_osc_en ##0 pwr_state == KBCP_STOP)
    else $error("stop left osc on");
  a_od_never_high: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    i_open_drain |-> !(o_keyboard_clock_pin_oe && o_keyboard_clock_pin_out))
    else $error("open drain drove high");
  a_ibf_clear: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    i_core_in_rd && !host_buf_wr |=> !in_buf_full) else $error("ibf not cleared");

  // host buffer writes
  a_cd_follow: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    host_buf_wr |=> status[KBCP_ST_CD] == $past(host_addr_line_two))
    else $error("command/data bit wrong");
  a_ibf_overwrite: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    host_buf_wr && in_buf_full |=> in_buf_full && in_buf == $past(i_host_wdata))
    else $error("overwrite while full wrong");
  a_in_buf_hold: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    !host_buf_wr |=> $stable(in_buf)) else $error("input buffer changed");

  // host reads
  a_rvalid_pulse: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    host_data_rd || host_status_rd |=> o_host_rvalid) else $error("no read valid");
  a_no_rvalid: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    !host_data_rd && !host_status_rd |=> !o_host_rvalid) else $error("stray read valid");
  a_obf_ungated: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    host_data_rd && !i_en_flags && !i_core_out_wr |=> out_buf_full == $past(out_buf_full))
    else $error("ungated read touched obf");

  // status byte
  a_status_reset: assert property (@(posedge i_ref_clk)
    $fell(i_reset) |-> status == KBCP_STATUS_RESET) else $error("status not cleared");
  a_ud_write: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    i_core_status_wr |=> (status & KBCP_UD_MASK) == ($past(i_core_status_data) & KBCP_UD_MASK))
    else $error("user bits wrong");

  // interrupt and gate A20 outputs
  a_kbd_direct: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    !i_en_flags |-> o_kbd_irq_out == port2[KBCP_P2_KBD_IRQ_OUT]) else $error("kbd irq not direct");
  a_kbd_forced_low: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    i_en_flags && !port2[KBCP_P2_KBD_IRQ_OUT] |-> !o_kbd_irq_out) else $error("kbd irq not low");
  a_aux_direct: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    !i_en_flags |-> o_aux_irq_out == port2[KBCP_P2_AIRQ]) else $error("aux irq not direct");
  a_a20_follow: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    o_gate_a20 == port2[KBCP_P2_A20]) else $error("gate a20 wrong");

  // power modes
  sequence s_sleep_wake;
    pwr_state != KBCP_RUN && wake;
  endsequence
  a_wake_call: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    s_sleep_wake ##0 i_ibf_int_en |=> o_wake_call_int && o_alu_clk_en)
    else $error("wake did not call");
  a_wake_next: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    s_sleep_wake ##0 !i_ibf_int_en |=> o_wake_next && o_alu_clk_en)
    else $error("wake did not continue");
  a_halt_enter: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    pwr_state == KBCP_RUN && i_halt && !i_stop |=> !o_alu_clk_en && o_osc_en)
    else $error("halt not entered");
  a_stop_hold: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    pwr_state == KBCP_STOP && !wake |=> !o_osc_en) else $error("stop left early");

  // pins
  a_kbd_invert: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    o_keyboard_clock_pin_out == !port2[KBCP_P2_KEYBOARD_CLOCK_PIN]) else $error("kbd clock not inverted");
  a_keyboard_data_pin_invert: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    o_keyboard_data_pin_out == !port2[KBCP_P2_KEYBOARD_DATA_PIN]) else $error("kbd data not inverted");
  a_mouse_invert: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    o_mouse_data_pin_out == !port2[KBCP_P2_MOUSE_DATA_PIN]) else $error("mouse data not inverted");
  a_mclk_invert: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    o_mouse_clock_pin_out == !port2[KBCP_P2_MCLK]) else $error("mouse clock not inverted");
  a_low_drives: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    !o_keyboard_data_pin_out |-> o_keyboard_data_pin_oe) else $error("low not driven");
endmodule : kbcp_host_port
`default_nettype wire

// *** testbench/kbcp_host_model.sv ***
`default_nettype none
module kbcp_host_model (
  input wire logic i_ref_clk, // controller clock
  input wire logic [7:0] i_rdata, // read data from the port
  input wire logic i_rvalid, // read data valid
  output logic [7:0] o_addr, // host address
  output logic o_wr, // write strobe
  output logic o_rd, // read strobe
  output logic [7:0] o_wdata // write data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_addr = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 8'h00;
  end
  // released bus lines show the inverse of the last value
  task automatic write(input logic [7:0] addr, input logic [7:0] data);
    @(negedge i_ref_clk);
    o_addr = addr;
    o_wdata = data;
    o_wr = 1'b1;
    @(negedge i_ref_clk);
    o_wr = 1'b0;
    o_addr = ~addr;
    o_wdata = ~data;
  endtask : write
  task automatic read(input logic [7:0] addr, output logic [7:0] data, output logic ok);
    @(negedge i_ref_clk);
    o_addr = addr;
    o_rd = 1'b1;
    @(negedge i_ref_clk);
    o_rd = 1'b0;
    o_addr = ~addr;
    ok = i_rvalid;
    data = i_rdata;
  endtask : read
endmodule : kbcp_host_model
`default_nettype wire

// *** testbench/tb_top.sv ***
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import kbcp_pkg::*;
  localparam int S_OUT = 0, S_IN = 1, S_P2 = 2, S_HALT = 3, S_STOP = 4;
  logic i_ref_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_host_wr, i_host_rd, o_host_rvalid, i_core_out_wr, i_core_in_rd, i_en_flags;
  logic i_port2_wr, i_open_drain, i_halt, i_stop, i_ibf_int_en, ok;
  logic o_alu_clk_en, o_osc_en, o_wake_call_int, o_wake_next, o_kbd_irq_out, o_aux_irq_out;
  logic o_core_ibf_irq, o_gate_a20, o_test_in_kbd_clk, o_test_in_mouse_clk;
  logic o_port_in_kbd_dat, o_port_in_mouse_dat;
  logic [7:0] i_host_addr, i_host_wdata, o_host_rdata, i_core_out_data, o_core_input_buffer;
  logic [7:0] i_port2_data, o_status, o_port2, d;
  logic [3:0] pin_out, pin_oe; // kbd clk, kbd dat, mouse clk, mouse dat
  wire [3:0] pin_lvl;
  int n_mismatch = 0;
  int checks_done = 0;
  int n;
  assign pin_lvl = (pin_oe & pin_out) | ~pin_oe; // external pull-ups
  always #25 i_ref_clk = ~i_ref_clk;
  kbcp_host_model i_host (.i_ref_clk(i_ref_clk), .i_rdata(o_host_rdata),
    .i_rvalid(o_host_rvalid), .o_addr(i_host_addr), .o_wr(i_host_wr), .o_rd(i_host_rd),
    .o_wdata(i_host_wdata));
  kbcp_host_port i_dut (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_host_addr(i_host_addr),
    .i_host_wr(i_host_wr), .i_host_rd(i_host_rd), .i_host_wdata(i_host_wdata),
    .o_host_rdata(o_host_rdata), .o_host_rvalid(o_host_rvalid), .i_core_out_wr(i_core_out_wr),
    .i_core_out_data(i_core_out_data), .i_core_in_rd(i_core_in_rd),
    .o_core_input_buffer(o_core_input_buffer), .i_core_status_wr(1'b0),
    .i_core_status_data(8'h00), .i_en_flags(i_en_flags), .i_port2_wr(i_port2_wr),
    .i_port2_data(i_port2_data), .i_open_drain(i_open_drain), .i_gp_input_cfg(1'b1),
    .i_gp_invert_cfg(1'b1), .i_halt(i_halt), .i_stop(i_stop), .i_ibf_int_en(i_ibf_int_en),
    .o_alu_clk_en(o_alu_clk_en), .o_osc_en(o_osc_en), .o_wake_call_int(o_wake_call_int),
    .o_wake_next(o_wake_next), .o_status(o_status), .o_port2(o_port2),
    .o_kbd_irq_out(o_kbd_irq_out), .o_aux_irq_out(o_aux_irq_out),
    .o_core_ibf_irq(o_core_ibf_irq), .o_gate_a20(o_gate_a20),
    .i_keyboard_clock_pin(pin_lvl[0]), .o_keyboard_clock_pin_out(pin_out[0]),
    .o_keyboard_clock_pin_oe(pin_oe[0]), .i_keyboard_data_pin(pin_lvl[1]),
    .o_keyboard_data_pin_out(pin_out[1]), .o_keyboard_data_pin_oe(pin_oe[1]),
    .i_mouse_clock_pin(pin_lvl[2]), .o_mouse_clock_pin_out(pin_out[2]),
    .o_mouse_clock_pin_oe(pin_oe[2]), .i_mouse_data_pin(pin_lvl[3]),
    .o_mouse_data_pin_out(pin_out[3]), .o_mouse_data_pin_oe(pin_oe[3]),
    .o_test_in_kbd_clk(o_test_in_kbd_clk), .o_test_in_mouse_clk(o_test_in_mouse_clk),
    .o_port_in_kbd_dat(o_port_in_kbd_dat), .o_port_in_mouse_dat(o_port_in_mouse_dat));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk
  task automatic chk_bit(input string what, input logic exp, input logic got);
    chk(what, {7'h00, exp}, {7'h00, got});
  endtask : chk_bit
  // one-cycle core strobe, sel picks which
  task automatic strobe(input int sel, input logic [7:0] v);
    @(negedge i_ref_clk);
    {i_core_out_wr, i_core_in_rd, i_port2_wr, i_halt, i_stop} = 5'h10 >> sel;
    i_core_out_data = v;
    i_port2_data = v;
    @(negedge i_ref_clk);
    {i_core_out_wr, i_core_in_rd, i_port2_wr, i_halt, i_stop} = 5'h00;
  endtask : strobe
  task automatic do_reset;
    i_reset = 1'b1;
    repeat (4) @(negedge i_ref_clk);
    i_reset = 1'b0;
  endtask : do_reset
  task automatic t_reset;
    chk("status", KBCP_STATUS_RESET, o_status);
    chk_bit("kbd irq", 1'b0, o_kbd_irq_out);
    $display("test reset done");
  endtask : t_reset
  task automatic t_host_buf;
    i_host.write(KBCP_ADDR_DATA, 8'ha5);
    chk("status", 8'h02, o_status);
    chk("in buf", 8'ha5, o_core_input_buffer);
    i_host.write(KBCP_ADDR_CMD, 8'h3c);
    chk("status", 8'h0a, o_status);
    chk("in buf", 8'h3c, o_core_input_buffer);
    i_host.write(8'h61, 8'hff);
    i_host.read(8'h65, d, ok);
    chk_bit("unmapped rvalid", 1'b0, ok);
    i_host.read(KBCP_ADDR_CMD, d, ok);
    chk_bit("rvalid", 1'b1, ok);
    chk("status read", 8'h0a, d);
    chk("in buf", 8'h3c, o_core_input_buffer);
    strobe(S_IN, 8'h00);
    chk("status", 8'h08, o_status);
    chk_bit("core irq", 1'b0, o_core_ibf_irq);
    $display("test host buffer done");
  endtask : t_host_buf
  task automatic t_gated;
    i_en_flags = 1'b1;
    strobe(S_P2, 8'h30);
    chk_bit("aux irq", 1'b1, o_aux_irq_out);
    i_host.write(KBCP_ADDR_DATA, 8'h11);
    chk_bit("aux irq", 1'b0, o_aux_irq_out);
    strobe(S_IN, 8'h00);
    strobe(S_OUT, 8'h5a);
    chk("status", 8'h01, o_status);
    chk_bit("kbd irq", 1'b1, o_kbd_irq_out);
    i_host.read(KBCP_ADDR_CMD, d, ok);
    chk("status", 8'h01, o_status);
    i_host.read(KBCP_ADDR_DATA, d, ok);
    chk("data read", 8'h5a, d);
    chk("status", 8'h00, o_status);
    chk_bit("kbd irq", 1'b0, o_kbd_irq_out);
    strobe(S_OUT, 8'h66);
    strobe(S_P2, 8'h20);
    chk_bit("kbd irq", 1'b0, o_kbd_irq_out);
    $display("test gated flags done");
  endtask : t_gated
  task automatic t_direct;
    logic [7:0] pats [4] = '{8'h00, 8'hff, 8'h52, 8'hac};
    logic [3:0] en;
    i_en_flags = 1'b0;
    i_open_drain = 1'b1;
    i_host.read(KBCP_ADDR_DATA, d, ok);
    chk("status", 8'h01, o_status);
    foreach (pats[k]) begin
      strobe(S_P2, pats[k]);
      en = {pats[k][2], pats[k][3], pats[k][7], pats[k][6]};
      chk_bit("kbd irq", pats[k][4], o_kbd_irq_out);
      chk_bit("aux irq", pats[k][5], o_aux_irq_out);
      chk_bit("gate a20", pats[k][1], o_gate_a20);
      chk("port2", pats[k], o_port2);
      chk({"pin oe"}, {4'h0, en}, {4'h0, pin_oe});
      chk({"pin level"}, {4'h0, ~en}, {4'h0, pin_lvl});
      repeat (3) @(negedge i_ref_clk);
      chk_bit("kbd clk in", ~en[0], o_test_in_kbd_clk);
      chk_bit("kbd dat in", ~en[1], o_port_in_kbd_dat);
      chk_bit("mouse clk in", ~en[2], o_test_in_mouse_clk);
      chk_bit("mouse dat in", ~en[3], o_port_in_mouse_dat);
    end
    $display("test direct port done");
  endtask : t_direct
  task automatic t_push_pull;
    i_open_drain = 1'b0;
    strobe(S_P2, 8'hc0);
    strobe(S_P2, 8'h00);
    n = 0;
    while (pin_oe[0] === 1'b1 && n < 20) begin
      chk_bit("pin drive", 1'b1, pin_out[0]);
      @(negedge i_ref_clk);
      n++;
    end
    chk("drive cycles", 8'(KBCP_PULLUP_CYCLES) + 8'h01, 8'(n));
    chk_bit("pin level", 1'b1, pin_lvl[0]);
    $display("test push pull done");
  endtask : t_push_pull
  task automatic t_power;
    i_ibf_int_en = 1'b1;
    strobe(S_HALT, 8'h00);
    chk_bit("alu clk", 1'b0, o_alu_clk_en);
    chk_bit("osc", 1'b1, o_osc_en);
    i_host.write(KBCP_ADDR_DATA, 8'h77);
    chk_bit("wake call", 1'b1, o_wake_call_int);
    chk_bit("core irq", 1'b1, o_core_ibf_irq);
    chk_bit("alu clk", 1'b1, o_alu_clk_en);
    strobe(S_IN, 8'h00);
    i_ibf_int_en = 1'b0;
    strobe(S_STOP, 8'h00);
    chk_bit("osc", 1'b0, o_osc_en);
    i_host.write(KBCP_ADDR_CMD, 8'h12);
    chk_bit("wake next", 1'b1, o_wake_next);
    chk_bit("osc", 1'b1, o_osc_en);
    strobe(S_HALT, 8'h00);
    do_reset();
    chk_bit("alu clk", 1'b1, o_alu_clk_en);
    chk("status", KBCP_STATUS_RESET, o_status);
    $display("test power modes done");
  endtask : t_power
  task automatic close_out;
    $display("checks %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out
  initial begin
    {i_core_out_wr, i_core_in_rd, i_port2_wr, i_halt, i_stop} = 5'h00;
    {i_en_flags, i_open_drain, i_ibf_int_en} = 3'h0;
    i_core_out_data = 8'h00;
    i_port2_data = 8'h00;
    do_reset();
    t_reset();
    t_host_buf();
    t_gated();
    t_direct();
    t_push_pull();
    t_power();
    close_out();
  end
  initial begin
    #2000000;
    n_mismatch++;
    close_out();
  end
endmodule : tb_top
`default_nettype wire
